/* mevr_checker.sv */
// assertions on the motion event block ports
`timescale 1ns/10ps
module mevr_checker (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] ext_src_lo,
  input wire [4:0] ext_src_hi,
  input wire irq_pin_first,
  input wire irq_pin_second,
  input wire [3:0] event_state
);
  reg [7:0] en_r;
  reg [7:0] rlo_r;
  reg [7:0] rhi_r;
  // --------------------------------------------------------------------
  // shadow of enable and routing bytes
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 8'h00;
      rlo_r <= 8'h00;
      rhi_r <= 8'h00;
    end else if (ce && reg_wr) begin
      if (reg_addr == 8'h5D) en_r <= reg_wdata;
      if (reg_addr == 8'h66) rlo_r <= reg_wdata;
      if (reg_addr == 8'h67) rhi_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  unmap_read_a: assert property (ce && reg_rd &&
    (reg_addr < 8'h5A || reg_addr > 8'h67) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  lo_first_a: assert property (ce &&
    |(ext_src_lo[5:0] & ~rlo_r[5:0]) |=> irq_pin_first)
    else $error("first pin missing");
  lo_second_a: assert property (ce &&
    |(ext_src_lo[5:0] & rlo_r[5:0]) |=> irq_pin_second)
    else $error("second pin missing");
  hi_first_a: assert property (ce &&
    |(ext_src_hi[3:1] & ~rhi_r[3:1]) |=> irq_pin_first)
    else $error("first pin missing");
  tap_second_a: assert property (ce && ext_src_hi[4] && rhi_r[5]
    |=> irq_pin_second) else $error("tap pin missing");
  strong_en_a: assert property ($rose(event_state[0])
    |-> en_r[7] && (en_r[6:4] != 3'b000)) else $error("strong not enabled");
  strong_pin_a: assert property ($rose(event_state[0]) && !rlo_r[6]
    |-> ##[0:1] irq_pin_first) else $error("strong pin missing");
  weak_en_a: assert property ($rose(event_state[1]) |-> en_r[0])
    else $error("weak not enabled");
  motion_pulse_a: assert property (event_state[3] |=> !event_state[3])
    else $error("motion pulse too long");
  motion_pin_a: assert property (event_state[3] && rhi_r[4]
    |-> irq_pin_second) else $error("motion pin missing");
  strong_c: cover property ($rose(event_state[0]));
  weak_c: cover property ($rose(event_state[1]));
  drop_c: cover property ($rose(event_state[2]));
  motion_c: cover property (event_state[3]);
endmodule // mevr_checker

/* mevr_core.v */
// motion event detection and interrupt pin routing
`timescale 1ns/10ps
`include "mevr_map.vh"

// Function
// - motion threshold joins low and high byte
// - low motion threshold byte, resets zero
// - exceed, wait block, exceed within proof
// - block selector in timing upper nibble
// - block codes decode to listed seconds
// - proof selector in timing lower nibble
// - proof codes decode to listed seconds
// - strong enable global bit7, axes 6..4
// - weak enable bit 0, bits 3..1 reserved
// - per-axis abs/8 above 13-bit strong level
// - strong event after 512 Hz dwell exceeded
// - all axes abs/8 below weak level
// - weak event after 512 Hz dwell exceeded
// - axis abs sum/8 below drop level
// - drop event after 512 Hz dwell exceeded
// - low route byte: one selects second pin
// - high route byte bits 4..0 likewise
// - tap routed by high byte bit 5
module mevr_core #(
  parameter DWELL_DIV = `MEVR_DWELL_DIV,
  parameter STEP_DIV = `MEVR_STEP_DIV
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire sample_valid,
  input wire [15:0] linear_sample_x,
  input wire [15:0] linear_sample_y,
  input wire [15:0] linear_sample_z,
  input wire [15:0] slope_x,
  input wire [15:0] slope_y,
  input wire [15:0] slope_z,
  input wire [7:0] ext_src_lo,
  input wire [4:0] ext_src_hi,
  output reg irq_pin_first,
  output reg irq_pin_second,
  output reg [3:0] event_state
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function [15:0] abs16;
    input [15:0] v;
    begin
      abs16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  // block time in 50 ms steps
  function [8:0] block_steps;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: block_steps = 9'h00A;
        4'h1: block_steps = 9'h014;
        4'h2: block_steps = 9'h01E;
        4'h3: block_steps = 9'h028;
        4'h4: block_steps = 9'h03C;
        4'h5: block_steps = 9'h050;
        4'h6: block_steps = 9'h064;
        4'h7: block_steps = 9'h078;
        4'h8: block_steps = 9'h000;
        4'h9: block_steps = 9'h0A0;
        4'hA: block_steps = 9'h0B4;
        4'hB: block_steps = 9'h0C8;
        4'hC: block_steps = 9'h0F0;
        4'hD: block_steps = 9'h118;
        4'hE: block_steps = 9'h12C;
        default: block_steps = 9'h140;
      endcase
    end
  endfunction

  // proof time in 50 ms steps
  function [8:0] proof_steps;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: proof_steps = 9'h004;
        4'h1: proof_steps = 9'h005;
        4'h2: proof_steps = 9'h006;
        4'h3: proof_steps = 9'h008;
        4'h4: proof_steps = 9'h00A;
        4'h5: proof_steps = 9'h00C;
        4'h6: proof_steps = 9'h00E;
        4'h7: proof_steps = 9'h010;
        4'h8: proof_steps = 9'h012;
        4'h9: proof_steps = 9'h014;
        4'hA: proof_steps = 9'h018;
        4'hB: proof_steps = 9'h01E;
        4'hC: proof_steps = 9'h024;
        4'hD: proof_steps = 9'h02A;
        4'hE: proof_steps = 9'h030;
        default: proof_steps = 9'h038;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  reg [7:0] sigmotion_level_lo_r;
  reg [7:0] sigmotion_level_hi_r;
  reg [7:0] sigmotion_timing_r;
  reg [7:0] strong_weak_accel_enables_r;
  reg [7:0] strong_accel_level_lo_r;
  reg [7:0] strong_accel_level_hi_r;
  reg [7:0] strong_accel_dwell_r;
  reg [7:0] weak_accel_level_lo_r;
  reg [7:0] weak_accel_level_hi_r;
  reg [7:0] weak_accel_dwell_r;
  reg [7:0] drop_level_r;
  reg [7:0] drop_dwell_r;
  reg [7:0] irq_route_lo_r;
  reg [7:0] irq_route_hi_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sigmotion_level_lo_r <= `MEVR_RST_BYTE;
      sigmotion_level_hi_r <= `MEVR_RST_BYTE;
      sigmotion_timing_r <= `MEVR_RST_BYTE;
      strong_weak_accel_enables_r <= `MEVR_RST_BYTE;
      strong_accel_level_lo_r <= `MEVR_RST_BYTE;
      strong_accel_level_hi_r <= `MEVR_RST_BYTE;
      strong_accel_dwell_r <= `MEVR_RST_BYTE;
      weak_accel_level_lo_r <= `MEVR_RST_BYTE;
      weak_accel_level_hi_r <= `MEVR_RST_BYTE;
      weak_accel_dwell_r <= `MEVR_RST_BYTE;
      drop_level_r <= `MEVR_RST_BYTE;
      drop_dwell_r <= `MEVR_RST_BYTE;
      irq_route_lo_r <= `MEVR_RST_BYTE;
      irq_route_hi_r <= `MEVR_RST_BYTE;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `MEVR_A_SIGMOTION_LEVEL_LO: sigmotion_level_lo_r <= reg_wdata;
        `MEVR_A_SIGMOTION_LEVEL_HI: sigmotion_level_hi_r <= reg_wdata;
        `MEVR_A_SIGMOTION_TIMING: sigmotion_timing_r <= reg_wdata;
        `MEVR_A_STRONG_WEAK_ENABLES: strong_weak_accel_enables_r <= reg_wdata;
        `MEVR_A_STRONG_LEVEL_LO: strong_accel_level_lo_r <= reg_wdata;
        `MEVR_A_STRONG_LEVEL_HI: strong_accel_level_hi_r <= reg_wdata;
        `MEVR_A_STRONG_DWELL: strong_accel_dwell_r <= reg_wdata;
        `MEVR_A_WEAK_LEVEL_LO: weak_accel_level_lo_r <= reg_wdata;
        `MEVR_A_WEAK_LEVEL_HI: weak_accel_level_hi_r <= reg_wdata;
        `MEVR_A_WEAK_DWELL: weak_accel_dwell_r <= reg_wdata;
        `MEVR_A_DROP_LEVEL: drop_level_r <= reg_wdata;
        `MEVR_A_DROP_DWELL: drop_dwell_r <= reg_wdata;
        `MEVR_A_IRQ_ROUTE_LO: irq_route_lo_r <= reg_wdata;
        `MEVR_A_IRQ_ROUTE_HI: irq_route_hi_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the read strobe; unmapped reads give zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `MEVR_RST_BYTE;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `MEVR_A_SIGMOTION_LEVEL_LO: reg_rdata <= sigmotion_level_lo_r;
        `MEVR_A_SIGMOTION_LEVEL_HI: reg_rdata <= sigmotion_level_hi_r;
        `MEVR_A_SIGMOTION_TIMING: reg_rdata <= sigmotion_timing_r;
        `MEVR_A_STRONG_WEAK_ENABLES: reg_rdata <= strong_weak_accel_enables_r;
        `MEVR_A_STRONG_LEVEL_LO: reg_rdata <= strong_accel_level_lo_r;
        `MEVR_A_STRONG_LEVEL_HI: reg_rdata <= strong_accel_level_hi_r;
        `MEVR_A_STRONG_DWELL: reg_rdata <= strong_accel_dwell_r;
        `MEVR_A_WEAK_LEVEL_LO: reg_rdata <= weak_accel_level_lo_r;
        `MEVR_A_WEAK_LEVEL_HI: reg_rdata <= weak_accel_level_hi_r;
        `MEVR_A_WEAK_DWELL: reg_rdata <= weak_accel_dwell_r;
        `MEVR_A_DROP_LEVEL: reg_rdata <= drop_level_r;
        `MEVR_A_DROP_DWELL: reg_rdata <= drop_dwell_r;
        `MEVR_A_IRQ_ROUTE_LO: reg_rdata <= irq_route_lo_r;
        `MEVR_A_IRQ_ROUTE_HI: reg_rdata <= irq_route_hi_r;
        default: reg_rdata <= `MEVR_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------------
  reg [23:0] dwell_div_r;
  reg [23:0] step_div_r;
  wire [31:0] dwell_last = DWELL_DIV - 1;
  wire [31:0] step_last = STEP_DIV - 1;
  wire tick_dwell = (dwell_div_r == dwell_last[23:0]);
  wire tick_step = (step_div_r == step_last[23:0]);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_div_r <= 24'h000000;
      step_div_r <= 24'h000000;
    end else if (ce) begin
      dwell_div_r <= tick_dwell ? 24'h000000 : dwell_div_r + 24'h000001;
      step_div_r <= tick_step ? 24'h000000 : step_div_r + 24'h000001;
    end
  end

  // ----------------------------------------------------------------------
  // acceleration conditions, held between samples
  // ----------------------------------------------------------------------
  wire [15:0] abs_x = abs16(linear_sample_x);
  wire [15:0] abs_y = abs16(linear_sample_y);
  wire [15:0] abs_z = abs16(linear_sample_z);
  wire [12:0] div_x = abs_x[15:`MEVR_SHIFT_DIV8];
  wire [12:0] div_y = abs_y[15:`MEVR_SHIFT_DIV8];
  wire [12:0] div_z = abs_z[15:`MEVR_SHIFT_DIV8];
  wire [17:0] abs_sum = {2'b00, abs_x} + {2'b00, abs_y} + {2'b00, abs_z};
  wire [14:0] sum_div = abs_sum[17:`MEVR_SHIFT_DIV8];
  wire [12:0] strong_level = {strong_accel_level_hi_r[`MEVR_F_HI5],
    strong_accel_level_lo_r};
  wire [12:0] weak_level = {weak_accel_level_hi_r[`MEVR_F_HI5],
    weak_accel_level_lo_r};
  wire [15:0] sig_level = {sigmotion_level_hi_r,
    sigmotion_level_lo_r};
  wire [7:0] en = strong_weak_accel_enables_r;

  wire strong_now = en[`MEVR_B_STRONG_ALL] && (
    (en[`MEVR_B_STRONG_X] && div_x > strong_level) ||
    (en[`MEVR_B_STRONG_Y] && div_y > strong_level) ||
    (en[`MEVR_B_STRONG_Z] && div_z > strong_level));
  wire weak_now = en[`MEVR_B_WEAK_ALL] && div_x < weak_level &&
    div_y < weak_level && div_z < weak_level;
  wire drop_now = sum_div < {7'h00, drop_level_r};
  wire slope_over = slope_x > sig_level || slope_y > sig_level ||
    slope_z > sig_level;

  reg strong_cond_r;
  reg weak_cond_r;
  reg drop_cond_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strong_cond_r <= 1'b0;
      weak_cond_r <= 1'b0;
      drop_cond_r <= 1'b0;
    end else if (ce && sample_valid) begin
      strong_cond_r <= strong_now;
      weak_cond_r <= weak_now;
      drop_cond_r <= drop_now;
    end
  end

  // ----------------------------------------------------------------------
  // dwell qualification
  // ----------------------------------------------------------------------
  wire strong_accel_event;
  wire weak_accel_event;
  wire drop_event;

  mevr_dwell u_strong (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_dwell),
    .cond(strong_cond_r),
    .limit(strong_accel_dwell_r),
    .hit(strong_accel_event)
  );

  mevr_dwell u_weak (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_dwell),
    .cond(weak_cond_r),
    .limit(weak_accel_dwell_r),
    .hit(weak_accel_event)
  );

  mevr_dwell u_drop (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick_dwell),
    .cond(drop_cond_r),
    .limit(drop_dwell_r),
    .hit(drop_event)
  );

  // ----------------------------------------------------------------------
  // significant motion sequence
  // ----------------------------------------------------------------------
  localparam SM_IDLE = 2'b00;
  localparam SM_BLOCK = 2'b01;
  localparam SM_PROOF = 2'b10;

  reg [1:0] sm_state_r;
  reg [1:0] sm_state_nxt;
  reg [8:0] sm_cnt_r;
  reg [8:0] sm_cnt_nxt;
  reg significant_motion_r;
  reg significant_motion_nxt;
  wire [8:0] blk = block_steps(sigmotion_timing_r[`MEVR_F_BLOCK_SEL]);
  wire [8:0] prf = proof_steps(sigmotion_timing_r[`MEVR_F_PROOF_SEL]);

  always @* begin
    sm_state_nxt = sm_state_r;
    sm_cnt_nxt = sm_cnt_r;
    significant_motion_nxt = 1'b0;
    case (sm_state_r)
      SM_IDLE: begin
        if (sample_valid && slope_over) begin
          sm_state_nxt = (blk == 9'h000) ? SM_PROOF : SM_BLOCK;
          sm_cnt_nxt = (blk == 9'h000) ? prf : blk;
        end
      end
      SM_BLOCK: begin
        if (tick_step) begin
          if (sm_cnt_r == 9'h001) begin
            sm_state_nxt = SM_PROOF;
            sm_cnt_nxt = prf;
          end else begin
            sm_cnt_nxt = sm_cnt_r - 9'h001;
          end
        end
      end
      SM_PROOF: begin
        if (sample_valid && slope_over) begin
          significant_motion_nxt = 1'b1;
          sm_state_nxt = SM_IDLE;
        end else if (tick_step) begin
          if (sm_cnt_r == 9'h001) begin
            sm_state_nxt = SM_IDLE;
          end else begin
            sm_cnt_nxt = sm_cnt_r - 9'h001;
          end
        end
      end
      default: begin
        sm_state_nxt = SM_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sm_state_r <= SM_IDLE;
      sm_cnt_r <= 9'h000;
      significant_motion_r <= 1'b0;
    end else if (ce) begin
      sm_state_r <= sm_state_nxt;
      sm_cnt_r <= sm_cnt_nxt;
      significant_motion_r <= significant_motion_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------------
  reg [7:0] lo_src;
  reg [7:0] hi_src;

  always @* begin
    lo_src = ext_src_lo;
    lo_src[`MEVR_R_WEAK] = weak_accel_event;
    lo_src[`MEVR_R_STRONG] = strong_accel_event;
    hi_src = 8'h00;
    hi_src[`MEVR_R_TAP] = ext_src_hi[4];
    hi_src[`MEVR_R_SIGMOTION] = significant_motion_r;
    hi_src[`MEVR_R_QMARK] = ext_src_hi[3];
    hi_src[`MEVR_R_GYRO_UPD] = ext_src_hi[2];
    hi_src[`MEVR_R_LIN_UPD] = ext_src_hi[1];
    hi_src[`MEVR_R_DROP] = drop_event;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_first <= 1'b0;
      irq_pin_second <= 1'b0;
      event_state <= 4'h0;
    end else if (ce) begin
      irq_pin_second <= |(lo_src & irq_route_lo_r) |
        |(hi_src & irq_route_hi_r);
      irq_pin_first <= |(lo_src & ~irq_route_lo_r) |
        |(hi_src & ~irq_route_hi_r);
      event_state <= {significant_motion_r, drop_event, weak_accel_event,
        strong_accel_event};
    end
  end

endmodule // mevr_core

/* mevr_dwell.v */
// dwell counter that qualifies a persisting condition
`timescale 1ns/10ps
module mevr_dwell (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire tick,
  input wire cond,
  input wire [7:0] limit,
  output wire hit
);

  reg [8:0] cnt_r;
  reg [8:0] cnt_nxt;

  // ----------------------------------------------------------------------
  // saturating count of base ticks while the condition holds
  // ----------------------------------------------------------------------
  always @* begin
    cnt_nxt = cnt_r;
    if (!cond) begin
      cnt_nxt = 9'h000;
    end else if (tick && cnt_r != 9'h1FF) begin
      cnt_nxt = cnt_r + 9'h001;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign hit = cond && (cnt_r > {1'b0, limit});

endmodule // mevr_dwell

/* mevr_host.sv */
// host side model: counts rising edges on both interrupt pins
`timescale 1ns/10ps
module mevr_host (
  input wire mclk,
  input wire rst_n,
  input wire irq_pin_first,
  input wire irq_pin_second,
  output reg [7:0] rises_first,
  output reg [7:0] rises_second
);
  reg prev_f;
  reg prev_s;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_f <= 1'b0;
      prev_s <= 1'b0;
      rises_first <= 8'h00;
      rises_second <= 8'h00;
    end else begin
      prev_f <= irq_pin_first;
      prev_s <= irq_pin_second;
      if (irq_pin_first && !prev_f) rises_first <= rises_first + 8'h01;
      if (irq_pin_second && !prev_s) rises_second <= rises_second + 8'h01;
    end
  end
endmodule // mevr_host

/* mevr_map.vh */
// register map, field positions and time bases of the motion event block
`ifndef MEVR_MAP_VH
`define MEVR_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MEVR_A_SIGMOTION_LEVEL_LO 8'h5A
`define MEVR_A_SIGMOTION_LEVEL_HI 8'h5B
`define MEVR_A_SIGMOTION_TIMING 8'h5C
`define MEVR_A_STRONG_WEAK_ENABLES 8'h5D
`define MEVR_A_STRONG_LEVEL_LO 8'h5E
`define MEVR_A_STRONG_LEVEL_HI 8'h5F
`define MEVR_A_STRONG_DWELL 8'h60
`define MEVR_A_WEAK_LEVEL_LO 8'h61
`define MEVR_A_WEAK_LEVEL_HI 8'h62
`define MEVR_A_WEAK_DWELL 8'h63
`define MEVR_A_DROP_LEVEL 8'h64
`define MEVR_A_DROP_DWELL 8'h65
`define MEVR_A_IRQ_ROUTE_LO 8'h66
`define MEVR_A_IRQ_ROUTE_HI 8'h67

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define MEVR_RST_BYTE 8'h00
`define MEVR_B_STRONG_ALL 7
`define MEVR_B_STRONG_X 6
`define MEVR_B_STRONG_Y 5
`define MEVR_B_STRONG_Z 4
`define MEVR_B_WEAK_ALL 0
`define MEVR_F_HI5 4:0
`define MEVR_F_BLOCK_SEL 7:4
`define MEVR_F_PROOF_SEL 3:0
`define MEVR_SHIFT_DIV8 3
// low routing byte
`define MEVR_R_WEAK 7
`define MEVR_R_STRONG 6
`define MEVR_R_INACT 5
`define MEVR_R_ACT 4
`define MEVR_R_DTAP 3
`define MEVR_R_STAP 2
`define MEVR_R_FLAT 1
`define MEVR_R_ORIENT 0
// high routing byte
`define MEVR_R_TAP 5
`define MEVR_R_SIGMOTION 4
`define MEVR_R_QMARK 3
`define MEVR_R_GYRO_UPD 2
`define MEVR_R_LIN_UPD 1
`define MEVR_R_DROP 0

// ----------------------------------------------------------------------
// time bases
// ----------------------------------------------------------------------
`define MEVR_CLK_HZ 125000000
`define MEVR_DWELL_HZ 512
// one step of the motion timers is 50 ms (20 Hz)
`define MEVR_STEP_HZ 20
`define MEVR_DWELL_DIV (`MEVR_CLK_HZ / `MEVR_DWELL_HZ)
`define MEVR_STEP_DIV (`MEVR_CLK_HZ / `MEVR_STEP_HZ)

`endif

/* tb_top.sv */
// self-checking bench for the motion event block
`timescale 1ns/10ps
module tb_top;
  reg mclk, rst_n, ce, reg_wr, reg_rd, sample_valid;
  reg [7:0] reg_addr, reg_wdata, ext_src_lo, k;
  reg [4:0] ext_src_hi;
  reg [15:0] lx, ly, lz, sx;
  wire [7:0] reg_rdata, rf, rs;
  wire irq_pin_first, irq_pin_second;
  wire [3:0] event_state;
  integer mismatches, check_count, cyc, i;
  mevr_core #(.DWELL_DIV(4), .STEP_DIV(8)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .linear_sample_x(lx),
    .linear_sample_y(ly), .linear_sample_z(lz), .slope_x(sx),
    .slope_y(16'h0000), .slope_z(16'h0000), .ext_src_lo(ext_src_lo),
    .ext_src_hi(ext_src_hi), .irq_pin_first(irq_pin_first),
    .irq_pin_second(irq_pin_second), .event_state(event_state));
  mevr_host u_host (.mclk(mclk), .rst_n(rst_n), .irq_pin_first(irq_pin_first),
    .irq_pin_second(irq_pin_second), .rises_first(rf), .rises_second(rs));
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task chk(input [8*10:1] nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk("reg read", {8'h00, e}, {8'h00, reg_rdata});
    end
  endtask
  task smp(input [15:0] x, input [15:0] y, input [15:0] z, input [15:0] s);
    begin
      @(negedge mclk);
      sample_valid = 1'b1;
      lx = x;
      ly = y;
      lz = z;
      sx = s;
      @(negedge mclk);
      sample_valid = 1'b0;
    end
  endtask
  // quiet window first, then a bounded wait for the expected level
  task ev(input integer b, input integer q, input e);
    integer n;
    begin
      n = 0;
      repeat (q) @(negedge mclk) if (event_state[b] === 1'b1) n = 1;
      chk("early", 16'h0000, n[15:0]);
      n = 0;
      while (n < 60 && event_state[b] !== e) begin
        @(negedge mclk);
        n = n + 1;
      end
      chk("event", {15'h0000, e}, {15'h0000, event_state[b]});
    end
  endtask
  task route(input [7:0] rl, input [7:0] rh, input [7:0] sl,
    input [4:0] sh, input f, input s);
    begin
      wr(8'h66, rl);
      wr(8'h67, rh);
      ext_src_lo = sl;
      ext_src_hi = sh;
      repeat (2) @(negedge mclk);
      chk("pin first", {15'h0000, f}, {15'h0000, irq_pin_first});
      chk("pin second", {15'h0000, s}, {15'h0000, irq_pin_second});
      ext_src_lo = 8'h00;
      ext_src_hi = 5'h00;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // --------------------------------------------------------------------
  // clock, hang limit and tests
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, sample_valid, reg_addr, reg_wdata} = 0;
    {lx, ly, lz, sx, ext_src_lo, ext_src_hi, k} = 0;
    {mismatches, check_count, cyc} = 0;
    ce = 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    for (i = 8'h5A; i < 8'h68; i = i + 1) rd(i[7:0], 8'h00);
    for (i = 8'h5A; i < 8'h68; i = i + 1) wr(i[7:0], i[7:0] ^ 8'hA5);
    for (i = 8'h5A; i < 8'h68; i = i + 1) rd(i[7:0], i[7:0] ^ 8'hA5);
    for (i = 8'h5A; i < 8'h68; i = i + 1) wr(i[7:0], 8'h00);
    wr(8'h70, 8'h3C);
    rd(8'h70, 8'h00);
    ce = 1'b0;
    wr(8'h5A, 8'h11);
    ce = 1'b1;
    rd(8'h5A, 8'h00);
    $display("test registers done");
    for (i = 0; i < 6; i = i + 1) begin
      route(8'h00, 8'h00, 8'h01 << i, 5'h00, 1'b1, 1'b0);
      route(8'h01 << i, 8'h00, 8'h01 << i, 5'h00, 1'b0, 1'b1);
    end
    for (i = 1; i < 5; i = i + 1) begin
      route(8'h00, 8'h00, 8'h00, 5'h01 << i, 1'b1, 1'b0);
      route(8'h00, (i == 4) ? 8'h20 : 8'h01 << i, 8'h00, 5'h01 << i,
        1'b0, 1'b1);
    end
    route(8'hFF, 8'hFF, 8'hC0, 5'h01, 1'b0, 1'b0);
    $display("test routing done");
    wr(8'h5E, 8'h10);
    wr(8'h5F, 8'hE1);
    wr(8'h60, 8'h02);
    wr(8'h5D, 8'hC0);
    wr(8'h66, 8'h00);
    smp(16'd2184, 0, 0, 0);
    repeat (6) @(negedge mclk);
    smp(0, 0, 0, 0);
    smp(16'd2184, 0, 0, 0);
    ev(0, 6, 1);
    @(negedge mclk);
    chk("pin first", 1, irq_pin_first);
    smp(16'd2176, 0, 0, 0);
    ev(0, 0, 0);
    smp(16'hF778, 0, 0, 0);
    ev(0, 6, 1);
    wr(8'h5D, 8'h40);
    smp(16'hF778, 16'd2184, 0, 0);
    ev(0, 0, 0);
    smp(16'd2184, 0, 0, 0);
    ev(0, 40, 0);
    wr(8'h5D, 8'hC0);
    smp(0, 16'd2184, 0, 0);
    ev(0, 40, 0);
    wr(8'h5D, 8'hA0);
    smp(0, 16'd2184, 0, 0);
    ev(0, 6, 1);
    smp(0, 0, 0, 0);
    ev(0, 0, 0);
    $display("test strong done");
    wr(8'h61, 8'h10);
    wr(8'h63, 8'h01);
    wr(8'h66, 8'h80);
    wr(8'h5D, 8'h01);
    smp(16'd120, 16'hFF88, 16'd120, 0);
    ev(1, 3, 1);
    @(negedge mclk);
    chk("pin second", 1, irq_pin_second);
    smp(16'd120, 16'd128, 16'd120, 0);
    ev(1, 0, 0);
    wr(8'h5D, 8'h00);
    smp(16'd120, 16'd120, 16'd120, 0);
    ev(1, 40, 0);
    $display("test weak done");
    wr(8'h64, 8'h0A);
    wr(8'h65, 8'h03);
    wr(8'h67, 8'h01);
    smp(16'd24, 16'hFFE8, 16'd24, 0);
    ev(2, 10, 1);
    @(negedge mclk);
    chk("pin second", 1, irq_pin_second);
    smp(16'd24, 16'd24, 16'd32, 0);
    ev(2, 0, 0);
    wr(8'h64, 8'h00);
    $display("test drop done");
    wr(8'h5B, 8'h01);
    wr(8'h5C, 8'h80);
    wr(8'h67, 8'h10);
    k = rs;
    for (i = 0; i < 2; i = i + 1) begin
      smp(0, 0, 0, 16'd256);
      smp(0, 0, 0, 0);
    end
    ev(3, 20, 0);
    smp(0, 0, 0, 16'd257);
    smp(0, 0, 0, 0);
    smp(0, 0, 0, 16'd257);
    ev(3, 0, 1);
    smp(0, 0, 0, 0);
    chk("host rises", k + 8'h01, rs);
    wr(8'h5C, 8'h01);
    for (i = 0; i < 2; i = i + 1) begin
      smp(0, 0, 0, 16'd300);
      smp(0, 0, 0, 0);
    end
    ev(3, 20, 0);
    repeat (60) @(negedge mclk);
    smp(0, 0, 0, 16'd300);
    ev(3, 0, 1);
    smp(0, 0, 0, 0);
    $display("test motion done");
    tally_and_finish;
  end
endmodule // tb_top
bind mevr_core mevr_checker u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_src_lo(ext_src_lo),
  .ext_src_hi(ext_src_hi), .irq_pin_first(irq_pin_first),
  .irq_pin_second(irq_pin_second), .event_state(event_state));
